// *** logic/fsr_status_reg_one.sv ***
// status register one of a serial nor flash, with its serial command front end
// assumes a mode 0/3 host on SPI_SCK_I and a glitch-free chip select pin
//
// Functional notes
// - bit 7 guard bit, read/write, reset reloads it from the copy
// - bit 6 picks 64 kB or 4 kB units
// - bit 5 protects bottom-up or top-down
// - bits 4:2 extent, reset reloads it from the copy, 000 means none
// - extent written by direct command 01h
// - reject program/erase hitting protected region
// - latch clear blocks program, erase; status write needs latch or 50h
// - latch zero after power-up and reset
// - incomplete command leaves latch set
// - aborted complete write command clears latch
// - command 06h sets write latch
// - command 50h leaves write latch alone
// - bit 0 busy flag, read-only, reset zero
// - 50h writes flops; 06h also non-volatile copy
module fsr_status_reg_one
   import fsr_pkg::*;
#(
   parameter int unsigned PROG_LEN   = PROG_CYCLES,
   parameter int unsigned ERASE_LEN  = ERASE_CYCLES,
   parameter int unsigned NV_LEN     = NV_CYCLES,
   parameter int          ARRAY_ADDR_W = 20
) (
   input  wire logic       REF_CLK_I,
   input  wire logic       RST_I,
   input  wire logic       SPI_SCK_I,
   input  wire logic       SPI_CS_N_I,
   input  wire logic       SPI_SI_I,
   output logic            SPI_SO_O,
   output logic            SPI_SO_OE_O,
   output logic [7:0]      STATUS_O,
   output logic [7:0]      NV_STATUS_O,
   output logic            ARRAY_GO_O
);
   initial begin
      if (ARRAY_ADDR_W < UNIT_LARGE_LOG2 || ARRAY_ADDR_W > 24)
         $error("fsr_status_reg_one: array address width out of range");
      if (PROG_LEN == 0 || ERASE_LEN == 0 || NV_LEN == 0)
         $error("fsr_status_reg_one: operation length must be nonzero");
   end

   function automatic fsr_op_t cmd_op(input logic [7:0] c);
      if (c == CMD_WRITE_ENABLE) return OP_WREN;
      else if (c == CMD_VOL_WRITE_ENABLE) return OP_VWREN;
      else if (c == CMD_WRITE_STATUS || c == CMD_IND_WRITE) return OP_WRSR;
      else if (c == CMD_PAGE_PROGRAM) return OP_PROG;
      else if (c == CMD_ERASE_SMALL || c == CMD_ERASE_MID || c == CMD_ERASE_LARGE) return OP_ERASE;
      else if (c == CMD_CHIP_ERASE_A || c == CMD_CHIP_ERASE_B) return OP_CHIP;
      else return OP_NONE;
   endfunction

   // byte index at which a command has been shifted in completely
   function automatic logic [2:0] cmd_len(input logic [7:0] c);
      if (c == CMD_WRITE_STATUS) return 3'h1;
      else if (c == CMD_IND_WRITE) return 3'h2;
      else if (c == CMD_PAGE_PROGRAM) return 3'h4;
      else if (cmd_op(c) == OP_ERASE) return 3'h3;
      else return 3'h0;
   endfunction

   // ---- link side, clocked by the serial clock ----
   logic        frame_rst;
   logic [2:0]  bit_cnt_reg;
   logic [2:0]  byte_cnt_reg;
   logic [7:0]  sh_reg;
   logic [7:0]  cmd_reg;
   logic [23:0] addr_reg;
   logic        rd_reg;
   logic        rd_zero_reg;
   logic [7:0]  out_reg;
   fsr_evt_t    evt_reg;
   logic        evt_tog_reg;
   logic [7:0]  snap_reg;
   logic        ack_reg;
   logic        mir_req_lnk;
   logic        mir_req_reg;
   logic [7:0]  mir_word_reg;
   logic [7:0]  sh_next;
   logic        byte_done;
   logic [7:0]  cmd_now;
   logic        emit;
   logic [23:0] emit_addr;
   logic [7:0]  snap_val;

   // chip select high ends the frame at once, whatever the clock does
   assign frame_rst = RST_I | SPI_CS_N_I;
   assign sh_next   = {sh_reg[6:0], SPI_SI_I};
   assign byte_done = bit_cnt_reg == 3'h7;
   assign cmd_now   = (byte_cnt_reg == 3'h0) ? sh_next : cmd_reg;
   assign emit_addr = (byte_cnt_reg == 3'h3) ? {addr_reg[15:0], sh_next} : addr_reg;
   // an event is only sent once the whole command is in
   assign emit      = byte_done && cmd_op(cmd_now) != OP_NONE
                      && byte_cnt_reg == cmd_len(cmd_now)
                      && !(cmd_now == CMD_IND_WRITE && addr_reg[7:0] != IND_ADDR_STATUS_ONE);
   assign snap_val  = rd_zero_reg ? 8'h00 : snap_reg;

   always_ff @(posedge SPI_SCK_I or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 3'h0;
         sh_reg       <= 8'h00;
         cmd_reg      <= 8'h00;
         addr_reg     <= 24'h00_0000;
         rd_reg       <= 1'b0;
         rd_zero_reg  <= 1'b0;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         sh_reg      <= sh_next;
         if (byte_done) begin
            if (byte_cnt_reg != 3'h7) byte_cnt_reg <= byte_cnt_reg + 3'h1;
            if (byte_cnt_reg == 3'h0) begin
               cmd_reg <= sh_next;
               if (sh_next == CMD_READ_STATUS) rd_reg <= 1'b1;
            end else if (byte_cnt_reg <= 3'h3) begin
               addr_reg <= {addr_reg[15:0], sh_next};
               if (byte_cnt_reg == 3'h1 && cmd_reg == CMD_IND_READ) begin
                  rd_reg      <= 1'b1;
                  rd_zero_reg <= sh_next != IND_ADDR_STATUS_ONE;
               end
            end
         end
      end
   end

   // event and snapshot state must survive chip select, so only RST_I clears it
   always_ff @(posedge SPI_SCK_I or posedge RST_I) begin
      if (RST_I) begin
         evt_reg     <= '0;
         evt_tog_reg <= 1'b0;
         snap_reg    <= STATUS_RESET;
         ack_reg     <= 1'b0;
      end else begin
         if (emit) begin
            evt_reg     <= '{op: cmd_op(cmd_now), cmd: cmd_now, addr: emit_addr, data: sh_next};
            evt_tog_reg <= ~evt_tog_reg;
         end
         if (mir_req_lnk != ack_reg) begin
            snap_reg <= mir_word_reg;
            ack_reg  <= mir_req_lnk;
         end
      end
   end

   // each new byte reloads the latest snapshot, so polling sees busy fall
   always_ff @(negedge SPI_SCK_I or posedge frame_rst) begin
      if (frame_rst) begin
         SPI_SO_O    <= 1'b0;
         SPI_SO_OE_O <= 1'b0;
         out_reg     <= 8'h00;
      end else if (rd_reg) begin
         SPI_SO_OE_O <= 1'b1;
         if (bit_cnt_reg == 3'h0) begin
            SPI_SO_O <= snap_val[7];
            out_reg  <= {snap_val[6:0], 1'b0};
         end else begin
            SPI_SO_O <= out_reg[7];
            out_reg  <= {out_reg[6:0], 1'b0};
         end
      end
   end

   fsr_sync #(.W(1), .RST_VAL(1'b0)) u_sync_mir (
      .clk_i (SPI_SCK_I),
      .rst_i (RST_I),
      .d_i   (mir_req_reg),
      .q_o   (mir_req_lnk)
   );

   // ---- core side ----
   logic                 cs_core;
   logic                 evt_tog_core;
   logic                 ack_core;
   logic [FRAME_END_DELAY-1:0] cs_dly_reg;
   logic                 evt_seen_reg;
   fsr_evt_t             pend_reg;
   logic                 pend_valid_reg;
   logic                 guard_low_reg;
   logic                 gran_reg;
   logic                 dir_reg;
   logic [2:0]           ext_reg;
   logic                 wel_reg;
   logic                 vol_en_reg;
   logic [7:0]           nv_reg = NV_INIT;
   logic                 boot_reg;
   fsr_state_t           state_reg;
   logic                 frame_end;
   logic                 exec;
   logic                 busy;
   logic                 wr_ok;
   logic                 array_op;
   logic                 hit;
   logic                 start;
   logic [31:0]          start_len;
   logic                 op_done;
   logic [7:0]           status;

   fsr_sync #(.W(3), .RST_VAL(3'b100)) u_sync_core (
      .clk_i (REF_CLK_I),
      .rst_i (RST_I),
      .d_i   ({SPI_CS_N_I, evt_tog_reg, ack_reg}),
      .q_o   ({cs_core, evt_tog_core, ack_core})
   );

   // does an operation on addr with the given span touch the protected region
   function automatic logic prot_hit(input logic [23:0] a, input int span, input logic [2:0] ext,
                                     input logic gran, input logic dir);
      logic [31:0] size;
      logic [31:0] len;
      logic [31:0] first;
      logic [31:0] last;
      size  = 32'h0000_0001 << ARRAY_ADDR_W;
      len   = 32'h0000_0001 << ((gran ? UNIT_SMALL_LOG2 : UNIT_LARGE_LOG2) + int'(ext) - 1);
      first = {8'h00, a} & ~((32'h0000_0001 << span) - 32'h0000_0001) & (size - 32'h0000_0001);
      last  = first + (32'h0000_0001 << span) - 32'h0000_0001;
      if (ext == 3'h0) return 1'b0;
      if (ext == 3'h7 || len >= size) return 1'b1;
      return dir ? (last >= size - len) : (first < len);
   endfunction

   // frame end waits past the event crossing so a last-edge event is never missed
   assign frame_end = ~cs_dly_reg[FRAME_END_DELAY-1] & cs_dly_reg[FRAME_END_DELAY-2];
   assign busy      = state_reg == ST_BUSY;
   assign exec      = frame_end & pend_valid_reg & ~busy;
   assign wr_ok     = wel_reg | vol_en_reg;
   assign array_op  = pend_reg.op == OP_PROG || pend_reg.op == OP_ERASE || pend_reg.op == OP_CHIP;
   assign hit       = prot_hit(pend_reg.addr,
                         pend_reg.op == OP_CHIP ? ARRAY_ADDR_W :
                         pend_reg.op == OP_PROG ? 0 :
                         pend_reg.cmd == CMD_ERASE_SMALL ? UNIT_SMALL_LOG2 :
                         pend_reg.cmd == CMD_ERASE_MID ? UNIT_MID_LOG2 : UNIT_LARGE_LOG2,
                         ext_reg, gran_reg, dir_reg);
   assign start     = exec && wel_reg && ((array_op && !hit) || pend_reg.op == OP_WRSR);
   assign start_len = pend_reg.op == OP_PROG ? PROG_LEN :
                      pend_reg.op == OP_WRSR ? NV_LEN : ERASE_LEN;
   assign status    = {guard_low_reg, gran_reg, dir_reg, ext_reg, wel_reg, busy};

   fsr_op_timer #(.CW(32)) u_timer (
      .clk_i   (REF_CLK_I),
      .rst_i   (RST_I),
      .start_i (start),
      .len_i   (start_len),
      .done_o  (op_done)
   );

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cs_dly_reg     <= '1;
         evt_seen_reg   <= 1'b0;
         pend_reg       <= '0;
         pend_valid_reg <= 1'b0;
      end else begin
         cs_dly_reg <= {cs_dly_reg[FRAME_END_DELAY-2:0], cs_core};
         if (evt_tog_core != evt_seen_reg) begin
            evt_seen_reg   <= evt_tog_core;
            pend_reg       <= evt_reg;
            pend_valid_reg <= 1'b1;
         end else if (frame_end) begin
            pend_valid_reg <= 1'b0;
         end
      end
   end

   // power-up clears the flops, then the first cycle restores the copy
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         guard_low_reg <= STATUS_RESET[BIT_GUARD_LOW];
         gran_reg      <= STATUS_RESET[BIT_GRAN];
         dir_reg       <= STATUS_RESET[BIT_DIR];
         ext_reg       <= STATUS_RESET[EXT_HI:EXT_LO];
         wel_reg       <= STATUS_RESET[BIT_WRITE_LATCH];
         vol_en_reg    <= 1'b0;
         boot_reg      <= 1'b1;
      end else if (boot_reg) begin
         boot_reg      <= 1'b0;
         guard_low_reg <= nv_reg[BIT_GUARD_LOW];
         gran_reg      <= nv_reg[BIT_GRAN];
         dir_reg       <= nv_reg[BIT_DIR];
         ext_reg       <= nv_reg[EXT_HI:EXT_LO];
      end else if (exec) begin
         case (pend_reg.op)
            OP_WREN:  wel_reg <= 1'b1;
            OP_VWREN: vol_en_reg <= 1'b1;
            OP_WRSR: begin
               if (wr_ok) begin
                  guard_low_reg <= pend_reg.data[BIT_GUARD_LOW];
                  gran_reg      <= pend_reg.data[BIT_GRAN];
                  dir_reg       <= pend_reg.data[BIT_DIR];
                  ext_reg       <= pend_reg.data[EXT_HI:EXT_LO];
               end
               wel_reg    <= 1'b0;
               vol_en_reg <= 1'b0;
            end
            OP_PROG, OP_ERASE, OP_CHIP: wel_reg <= 1'b0;
            default: wel_reg <= wel_reg;
         endcase
      end
   end

   // the copy is storage: reset must not wipe what boot restores
   always_ff @(posedge REF_CLK_I) begin
      if (exec && pend_reg.op == OP_WRSR && wel_reg) begin
         nv_reg <= {pend_reg.data[7:2], 2'b00};
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_reg    <= ST_IDLE;
         STATUS_O     <= STATUS_RESET;
         NV_STATUS_O  <= NV_INIT;
         ARRAY_GO_O   <= 1'b0;
         mir_word_reg <= STATUS_RESET;
         mir_req_reg  <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: if (start) state_reg <= ST_BUSY;
            ST_BUSY: if (op_done) state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
         STATUS_O    <= status;
         NV_STATUS_O <= nv_reg;
         ARRAY_GO_O  <= start && array_op;
         // new snapshot only after the link side took the previous one
         if (ack_core == mir_req_reg && mir_word_reg != status) begin
            mir_word_reg <= status;
            mir_req_reg  <= ~mir_req_reg;
         end
      end
   end

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   chk_wren_sets_latch: assert property (
      exec && pend_reg.op == OP_WREN |=> wel_reg ##1 STATUS_O[BIT_WRITE_LATCH])
      else $error("write enable did not set the latch");
   chk_vwren_keeps_latch: assert property (
      exec && pend_reg.op == OP_VWREN |=> wel_reg == $past(wel_reg) && vol_en_reg)
      else $error("volatile enable changed the latch");
   chk_guarded_write: assert property (
      exec && pend_reg.op == OP_WRSR && !wr_ok |=> $stable(ext_reg) && $stable(gran_reg)
         && $stable(dir_reg) && $stable(guard_low_reg))
      else $error("status write accepted without enable");
   chk_extent_update: assert property (
      exec && pend_reg.op == OP_WRSR && wr_ok |=> ext_reg == $past(pend_reg.data[EXT_HI:EXT_LO]))
      else $error("extent not taken from status write");
   chk_partial_keeps: assert property (
      frame_end && !pend_valid_reg && !boot_reg |=> wel_reg == $past(wel_reg))
      else $error("incomplete command changed the latch");
   chk_complete_clears: assert property (
      exec && (array_op || pend_reg.op == OP_WRSR) |=> !wel_reg ##1 STATUS_O[BIT_WRITE_LATCH] == 1'b0)
      else $error("complete write command left the latch set");
   chk_protect_blocks: assert property (
      exec && array_op && hit |=> !busy && !ARRAY_GO_O)
      else $error("protected region accepted program or erase");
   chk_busy_holds: assert property (
      start |=> busy [*8])
      else $error("busy dropped early");
   chk_busy_clear: assert property (
      busy && op_done |=> !busy ##1 !STATUS_O[BIT_BUSY])
      else $error("busy not cleared at completion");
   chk_nv_copy: assert property (
      exec && pend_reg.op == OP_WRSR && !wel_reg |=> $stable(nv_reg))
      else $error("volatile write touched the non-volatile copy");
endmodule // fsr_status_reg_one

// *** logic/fsr_pkg.sv ***
// constants and carrier types for status register one of a serial nor flash
// assumes a 250 mhz core clock and a mode 0/3 serial link on its own clock
package fsr_pkg;

   // serial command codes
   localparam logic [7:0] CMD_WRITE_STATUS     = 8'h01;
   localparam logic [7:0] CMD_READ_STATUS      = 8'h05;
   localparam logic [7:0] CMD_WRITE_ENABLE     = 8'h06;
   localparam logic [7:0] CMD_VOL_WRITE_ENABLE = 8'h50;
   localparam logic [7:0] CMD_IND_READ         = 8'h65;
   localparam logic [7:0] CMD_IND_WRITE        = 8'h71;
   localparam logic [7:0] CMD_PAGE_PROGRAM     = 8'h02;
   localparam logic [7:0] CMD_ERASE_SMALL      = 8'h20;
   localparam logic [7:0] CMD_ERASE_MID        = 8'h52;
   localparam logic [7:0] CMD_ERASE_LARGE      = 8'hD8;
   localparam logic [7:0] CMD_CHIP_ERASE_A     = 8'h60;
   localparam logic [7:0] CMD_CHIP_ERASE_B     = 8'hC7;
   localparam logic [7:0] IND_ADDR_STATUS_ONE  = 8'h01;

   // field positions of the status byte
   localparam int BIT_GUARD_LOW  = 7;
   localparam int BIT_GRAN       = 6;
   localparam int BIT_DIR        = 5;
   localparam int EXT_HI         = 4;
   localparam int EXT_LO         = 2;
   localparam int BIT_WRITE_LATCH = 1;
   localparam int BIT_BUSY       = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] NV_INIT      = 8'h00;

   // protection and erase unit sizes as address bit counts
   localparam int UNIT_SMALL_LOG2 = 12;
   localparam int UNIT_MID_LOG2   = 15;
   localparam int UNIT_LARGE_LOG2 = 16;

   // internal operation times and derived cycle counts
   localparam int unsigned REF_PERIOD_NS     = 4;
   localparam int unsigned PROG_TIME_US      = 100;
   localparam int unsigned ERASE_TIME_US     = 1000;
   localparam int unsigned NV_WRITE_TIME_US  = 20;
   localparam int unsigned PROG_CYCLES  = (PROG_TIME_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int unsigned ERASE_CYCLES = (ERASE_TIME_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int unsigned NV_CYCLES    = (NV_WRITE_TIME_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int unsigned FRAME_END_DELAY = 3;

   typedef enum logic [2:0] {
      OP_NONE, OP_WREN, OP_VWREN, OP_WRSR, OP_PROG, OP_ERASE, OP_CHIP
   } fsr_op_t;

   typedef struct packed {
      fsr_op_t     op;
      logic [7:0]  cmd;
      logic [23:0] addr;
      logic [7:0]  data;
   } fsr_evt_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } fsr_state_t;

endpackage

// *** logic/fsr_sync.sv ***
// two-stage synchroniser for a bundle of independent levels
// assumes each bit changes slowly relative to the destination clock
module fsr_sync #(
   parameter int         W        = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= RST_VAL;
         q_o      <= RST_VAL;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule // fsr_sync

// *** logic/fsr_op_timer.sv ***
// down counter timing one internal program, erase or copy operation
// assumes start_i is a single-cycle pulse while the counter is idle
module fsr_op_timer #(
   parameter int CW = 32
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          start_i,
   input  wire logic [CW-1:0] len_i,
   output logic               done_o
);
   logic [CW-1:0] cnt_reg;
   logic          run_reg;

   initial begin
      if (CW < 2) $error("fsr_op_timer: counter too narrow");
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt_reg <= len_i;
            run_reg <= 1'b1;
         end else if (run_reg) begin
            if (cnt_reg <= CW'(1)) begin
               run_reg <= 1'b0;
               done_o  <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - CW'(1);
            end
         end
      end
   end
endmodule // fsr_op_timer

// *** test/fsr_host_model.sv ***
// host side of the serial link: mode 0 master issuing status frames
// assumes the device samples si on rising sck and drives so on falling sck
module fsr_host_model (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o,
   input  wire logic so_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b1;
   end
   // sck only toggles inside a frame, 48 ns period; rd keeps the last 8 bits seen
   task automatic xfer(input logic [63:0] v, input int n, output logic [7:0] rd);
      rd = 8'h00;
      #7 cs_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_o = v[63-i];
         #24 sck_o = 1'b1;
         rd = {rd[6:0], so_i};
         #24 sck_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      // released line shows the inverse, never a stale bit
      si_o = ~si_o;
      #60;
   endtask
endmodule // fsr_host_model

// *** test/test_fsr_status_reg_one.sv ***
// self-checking bench for status register one over its serial command link
// assumes the host model drives the link; operation lengths are shortened
module test_fsr_status_reg_one
   import fsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned NV_L = 20;
   localparam int unsigned PG_L = 200;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       sck, cs_n, si, so, so_oe, go;
   logic [7:0] status, nv_status, rd;
   int         n_errors = 0;
   int         n_compared = 0;
   int         n_go = 0;
   int         n_busy = 0;
   int         n_oe = 0;
   always #2 ref_clk = ~ref_clk;
   always @(posedge sck) begin
      if (so_oe === 1'b1) n_oe++;
   end
   always @(posedge ref_clk) begin
      if (go === 1'b1) n_go++;
      if (status[BIT_BUSY] === 1'b1) n_busy++;
   end
   fsr_status_reg_one #(.PROG_LEN(PG_L), .ERASE_LEN(PG_L), .NV_LEN(NV_L)) fsr_status_reg_one_inst (
      .REF_CLK_I(ref_clk), .RST_I(rst), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
      .SPI_SI_I(si), .SPI_SO_O(so), .SPI_SO_OE_O(so_oe), .STATUS_O(status),
      .NV_STATUS_O(nv_status), .ARRAY_GO_O(go));
   fsr_host_model fsr_host_model_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (12) @(posedge ref_clk);
   endtask
   // one frame, then wait out any internal operation before the next
   task automatic send(input logic [63:0] v, input int n);
      int k;
      k = 0;
      fsr_host_model_inst.xfer(v, n, rd);
      repeat (12) @(posedge ref_clk);
      while (status[BIT_BUSY] !== 1'b0 && k < 1000) begin
         @(posedge ref_clk);
         k++;
      end
      if (k == 1000) begin
         n_errors++;
         finish_test();
      end
   endtask
   initial begin
      @(posedge ref_clk);
      do_reset();
      check8("status after reset", 8'h00, status);
      send({CMD_READ_STATUS, 56'h0}, 16);
      check8("read 05h", 8'h00, rd);
      check8("so enable reading", 8'h08, n_oe[7:0]);
      check8("so enable idle", 8'h00, {7'h0, so_oe});
      send({CMD_WRITE_STATUS, 8'hFC, 48'h0}, 16);
      check8("write without latch", 8'h00, status);
      // walk a one through every writable bit on the volatile path
      for (int b = 2; b < 9; b++) begin
         send({CMD_VOL_WRITE_ENABLE, 56'h0}, 8);
         check8("latch after 50h", 8'h00, status & 8'h02);
         send({CMD_WRITE_STATUS, (b == 8) ? 8'hFF : 8'h01 << b, 48'h0}, 16);
         check8("volatile field", (b == 8) ? 8'hFC : 8'h01 << b, status);
         check8("copy after volatile", 8'h00, nv_status);
      end
      send({CMD_WRITE_ENABLE, 56'h0}, 8);
      check8("latch after 06h", 8'hFE, status);
      send({CMD_WRITE_STATUS, 56'h0}, 12);
      send({8'hAB, 56'h0}, 8);
      check8("latch after partial", 8'hFE, status);
      n_busy = 0;
      send({CMD_IND_WRITE, IND_ADDR_STATUS_ONE, 8'h24, 40'h0}, 27);
      check8("after 71h write", 8'h24, status);
      check8("copy after 71h", 8'h24, nv_status);
      check8("busy cycles", 8'h01, {7'h0, n_busy >= NV_L && n_busy <= NV_L + 4});
      send({CMD_READ_STATUS, 56'h0}, 32);
      check8("polled read", 8'h24, rd);
      send({CMD_IND_READ, IND_ADDR_STATUS_ONE, 48'h0}, 24);
      check8("indirect read", 8'h24, rd);
      // top 64 kB guarded: a program there must not start
      n_go = 0;
      send({CMD_WRITE_ENABLE, 56'h0}, 8);
      send({CMD_PAGE_PROGRAM, 24'h0F_FF00, 8'h5A, 24'h0}, 40);
      check8("protected program", 8'h24, status);
      check8("go protected", 8'h00, n_go[7:0]);
      send({CMD_WRITE_ENABLE, 56'h0}, 8);
      n_busy = 0;
      send({CMD_PAGE_PROGRAM, 24'h00_0000, 8'h5A, 24'h0}, 40);
      check8("go open", 8'h01, n_go[7:0]);
      check8("prog busy", 8'h01, {7'h0, n_busy >= PG_L && n_busy <= PG_L + 4});
      send({CMD_PAGE_PROGRAM, 24'h00_0000, 8'h5A, 24'h0}, 40);
      check8("go no latch", 8'h01, n_go[7:0]);
      send({CMD_WRITE_ENABLE, 56'h0}, 8);
      // no wait after the erase: read while it runs, then poll until ready
      fsr_host_model_inst.xfer({CMD_ERASE_SMALL, 56'h0}, 32, rd);
      fsr_host_model_inst.xfer({CMD_READ_STATUS, 56'h0}, 16, rd);
      check8("poll busy", 8'h25, rd);
      send({CMD_READ_STATUS, 56'h0}, 40);
      check8("poll ready", 8'h24, rd);
      send({CMD_WRITE_ENABLE, 56'h0}, 8);
      send({CMD_ERASE_MID, 56'h0}, 32);
      send({CMD_WRITE_ENABLE, 56'h0}, 8);
      send({CMD_ERASE_LARGE, 56'h0}, 32);
      check8("go erases", 8'h04, n_go[7:0]);
      send({CMD_WRITE_ENABLE, 56'h0}, 8);
      do_reset();
      check8("status after reset", 8'h24, status);
      finish_test();
   end
endmodule // test_fsr_status_reg_one
